// [design/olt_pkg.sv]
// constants, types and register map of the otp led trim block
package olt_pkg;
    localparam logic [6:0] I2C_DEV_ADDR = 7'h28;
    localparam logic [7:0] REG_SWITCHER_CURRENT_TRIM = 8'h01;
    localparam logic [7:0] REG_LINEAR_CURRENT_TRIM = 8'h02;
    localparam logic [7:0] REG_OTP_CTRL = 8'hff;
    localparam logic [5:0] SWITCHER_CURRENT_TRIM_RST = 6'h1f;
    localparam logic [3:0] LINEAR_CURRENT_TRIM_RST = 4'h7;
    localparam logic [7:0] CTRL_RST = 8'h08;
    localparam int CTRL_BURNED_BIT = 4;
    localparam int CTRL_BURN_BIT = 2;
    localparam int CTRL_RELOAD_BIT = 0;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam int OTP_READ_US = 50;
    localparam int OSC_KHZ = 500;
    localparam int OTP_READ_CYC = (OTP_READ_US * OSC_KHZ) / 1000;
    localparam logic [5:0] OTP_READ_LAST = 6'(OTP_READ_CYC - 1);
    localparam logic [5:0] OCNT_ZERO = 6'h00;
    localparam logic [5:0] OCNT_ONE = 6'h01;
    localparam logic [3:0] BCNT_ZERO = 4'h0;
    localparam logic [3:0] BCNT_ONE = 4'h1;

    typedef struct packed {
        logic burned;
        logic [5:0] switcher_current_trim;
        logic [3:0] linear_current_trim;
    } olt_otp_word_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV = 3'b001,
        ST_REG = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_SKIP = 3'b101
    } olt_i2c_state_t;
endpackage

// [design/olt_trim_top.sv]
// i2c trim register bank with otp load and burn control
// Function
// - switcher trim, 6 bits at 01h
// - power-up loads both trims from otp
// - switcher code steers current, 31 is neutral
// - linear trim, 4 bits at 02h, resets 07h
// - linear code steers current, 7 is neutral
// - control register at FFh resets to 08h
// - burned flag changes only on otp read
// - burn bit raises program supply to 8V
// - reload bit reloads trims, reads zero
// - oscillator runs only during otp read
// - power-on read starts when supply is good
// - all otp registers load together
// - i2c slave at address 28h, reg then data
// - write lands on final ack rising edge
`timescale 1ns/10ps
`default_nettype none
module olt_trim_top
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic osc_clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out_out,
    output logic sda_oe_out,
    input wire logic power_good_in,
    input wire olt_pkg::olt_otp_word_t otp_word_in,
    output logic [5:0] switcher_current_trim_out,
    output logic [3:0] linear_current_trim_out,
    output logic otp_program_supply_hv_out,
    output logic osc_en_out,
    output logic otp_busy_out
);
    import olt_pkg::*;

    function automatic logic [7:0] rd_value(input logic [7:0] addr, input logic [5:0] st,
                                            input logic [3:0] lt, input logic bn,
                                            input logic bu);
        logic [7:0] v;
        v = 8'h00;
        if (addr == REG_SWITCHER_CURRENT_TRIM)
        begin
            v = {2'h0, st};
        end
        else if (addr == REG_LINEAR_CURRENT_TRIM)
        begin
            v = {4'h0, lt};
        end
        else if (addr == REG_OTP_CTRL)
        begin
            v = CTRL_RST;
            v[CTRL_BURNED_BIT] = bn;
            v[CTRL_BURN_BIT] = bu;
        end
        return v;
    endfunction

    logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
    logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
    logic pwr_s1_reg, pwr_s2_reg;
    logic done_s1_reg, done_s2_reg, done_s3_reg;
    olt_i2c_state_t state_reg;
    logic [3:0] cnt_reg;
    logic in_ack_reg;
    logic data_ack_reg;
    logic [7:0] sh_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic sda_oe_reg;
    logic [5:0] switcher_current_trim_reg;
    logic [3:0] linear_current_trim_reg;
    logic burned_reg;
    logic burn_reg;
    logic busy_reg;
    logic osc_en_reg;
    logic req_tgl_reg;
    logic por_pend_reg;
    // link side, oscillator domain
    logic ors1_reg, ors2_reg;
    logic req_s1_reg, req_s2_reg, req_s3_reg;
    olt_otp_word_t otp_s1_reg, otp_s2_reg, cap_reg;
    logic orun_reg;
    logic [5:0] ocnt_reg;
    logic done_tgl_reg;

    wire scl_rise = scl_s2_reg & ~scl_s3_reg;
    wire scl_fall = ~scl_s2_reg & scl_s3_reg;
    wire start_cond = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
    wire stop_cond = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;
    wire addr_hit = (sh_reg[7:1] == I2C_DEV_ADDR);
    wire [7:0] rd_val = rd_value(ptr_reg, switcher_current_trim_reg, linear_current_trim_reg, burned_reg, burn_reg);
    wire wr_commit = scl_rise & in_ack_reg & data_ack_reg & (state_reg == ST_WDATA);
    wire wr_switcher_current_trim = wr_commit & (ptr_reg == REG_SWITCHER_CURRENT_TRIM);
    wire wr_linear_current_trim = wr_commit & (ptr_reg == REG_LINEAR_CURRENT_TRIM);
    wire wr_ctrl = wr_commit & (ptr_reg == REG_OTP_CTRL);
    wire reload_req = wr_ctrl & sh_reg[CTRL_RELOAD_BIT];
    wire por_start = por_pend_reg & pwr_s2_reg;
    wire start_read = ~busy_reg & (por_start | reload_req);
    wire load_now = done_s2_reg ^ done_s3_reg;
    wire req_edge = req_s2_reg ^ req_s3_reg;

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= 3'h7;
            {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= 3'h7;
            {pwr_s1_reg, pwr_s2_reg} <= 2'h0;
            {done_s1_reg, done_s2_reg, done_s3_reg} <= 3'h0;
        end
        else
        begin
            {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= {scl_in, scl_s1_reg, scl_s2_reg};
            {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= {sda_in, sda_s1_reg, sda_s2_reg};
            {pwr_s1_reg, pwr_s2_reg} <= {power_good_in, pwr_s1_reg};
            {done_s1_reg, done_s2_reg, done_s3_reg} <= {done_tgl_reg, done_s1_reg, done_s2_reg};
        end
    end

    // i2c slave: bits shift on scl rise, sda changes on scl fall
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= BCNT_ZERO;
            in_ack_reg <= 1'b0;
            sh_reg <= 8'h00;
            data_ack_reg <= 1'b0;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            sda_oe_reg <= 1'b0;
        end
        else if (start_cond)
        begin
            state_reg <= ST_DEV;
            cnt_reg <= BCNT_ZERO;
            in_ack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end
        else if (stop_cond)
        begin
            state_reg <= ST_IDLE;
            in_ack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end
        else if (state_reg != ST_IDLE && scl_rise)
        begin
            if (!in_ack_reg)
            begin
                sh_reg <= {sh_reg[6:0], sda_s2_reg};
                cnt_reg <= cnt_reg + BCNT_ONE;
            end
            else if (state_reg == ST_RDATA && sda_s2_reg)
            begin
                state_reg <= ST_SKIP;
            end
        end
        else if (state_reg != ST_IDLE && scl_fall)
        begin
            if (in_ack_reg)
            begin
                in_ack_reg <= 1'b0;
                cnt_reg <= BCNT_ZERO;
                tx_reg <= rd_val;
                sda_oe_reg <= (state_reg == ST_RDATA) & ~rd_val[7];
            end
            else if (cnt_reg == BIT_ACK)
            begin
                in_ack_reg <= 1'b1;
                // the register address ack must not commit; only a data byte ack does
                data_ack_reg <= (state_reg == ST_WDATA);
                case (state_reg)
                    ST_DEV:
                    begin
                        sda_oe_reg <= addr_hit;
                        state_reg <= !addr_hit ? ST_SKIP : (sh_reg[0] ? ST_RDATA : ST_REG);
                    end
                    ST_REG:
                    begin
                        sda_oe_reg <= 1'b1;
                        ptr_reg <= sh_reg;
                        state_reg <= ST_WDATA;
                    end
                    ST_WDATA: sda_oe_reg <= 1'b1;
                    default: sda_oe_reg <= 1'b0;
                endcase
            end
            else if (state_reg == ST_RDATA)
            begin
                tx_reg <= {tx_reg[6:0], 1'b0};
                sda_oe_reg <= ~tx_reg[6];
            end
        end
    end

    // trims and otp control; a finished read and a host write in one cycle: the write wins
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            switcher_current_trim_reg <= SWITCHER_CURRENT_TRIM_RST;
            linear_current_trim_reg <= LINEAR_CURRENT_TRIM_RST;
            burned_reg <= 1'b0;
            burn_reg <= 1'b0;
            busy_reg <= 1'b0;
            osc_en_reg <= 1'b0;
            req_tgl_reg <= 1'b0;
            por_pend_reg <= 1'b1;
        end
        else
        begin
            if (load_now)
            begin
                switcher_current_trim_reg <= cap_reg.switcher_current_trim;
                linear_current_trim_reg <= cap_reg.linear_current_trim;
                burned_reg <= cap_reg.burned;
                busy_reg <= 1'b0;
                osc_en_reg <= 1'b0;
            end
            if (wr_switcher_current_trim)
            begin
                switcher_current_trim_reg <= sh_reg[5:0];
            end
            if (wr_linear_current_trim)
            begin
                linear_current_trim_reg <= sh_reg[3:0];
            end
            if (wr_ctrl)
            begin
                burn_reg <= sh_reg[CTRL_BURN_BIT];
            end
            if (start_read)
            begin
                busy_reg <= 1'b1;
                osc_en_reg <= 1'b1;
                req_tgl_reg <= ~req_tgl_reg;
            end
            por_pend_reg <= ~pwr_s2_reg | (por_pend_reg & ~start_read);
        end
    end

    // oscillator domain: counts the read, samples the otp array, returns a toggle
    always_ff @(posedge osc_clk_in)
    begin
        ors1_reg <= rst_n_in;
        ors2_reg <= ors1_reg;
    end

    always_ff @(posedge osc_clk_in)
    begin
        if (!ors2_reg)
        begin
            {req_s1_reg, req_s2_reg, req_s3_reg} <= 3'h0;
            otp_s1_reg <= '0;
            otp_s2_reg <= '0;
            cap_reg <= '0;
            orun_reg <= 1'b0;
            ocnt_reg <= OCNT_ZERO;
            done_tgl_reg <= 1'b0;
        end
        else
        begin
            {req_s1_reg, req_s2_reg, req_s3_reg} <= {req_tgl_reg, req_s1_reg, req_s2_reg};
            otp_s1_reg <= otp_word_in;
            otp_s2_reg <= otp_s1_reg;
            if (!orun_reg && req_edge)
            begin
                orun_reg <= 1'b1;
                ocnt_reg <= OCNT_ZERO;
            end
            else if (orun_reg && ocnt_reg == OTP_READ_LAST)
            begin
                orun_reg <= 1'b0;
                cap_reg <= otp_s2_reg;
                done_tgl_reg <= ~done_tgl_reg;
            end
            else if (orun_reg)
            begin
                ocnt_reg <= ocnt_reg + OCNT_ONE;
            end
        end
    end

    assign sda_out_out = 1'b0;
    assign sda_oe_out = sda_oe_reg;
    assign switcher_current_trim_out = switcher_current_trim_reg;
    assign linear_current_trim_out = linear_current_trim_reg;
    assign otp_program_supply_hv_out = burn_reg;
    assign osc_en_out = osc_en_reg;
    assign otp_busy_out = busy_reg;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_burn_hv_set: assert property (wr_ctrl |=> otp_program_supply_hv_out == $past(sh_reg[2]))
        else $error("program supply does not follow burn bit");
    a_switcher_current_trim_write: assert property (wr_switcher_current_trim |=> switcher_current_trim_out == $past(sh_reg[5:0]))
        else $error("switcher trim write lost");
    a_linear_current_trim_write: assert property (wr_linear_current_trim |=> linear_current_trim_out == $past(sh_reg[3:0]))
        else $error("linear trim write lost");
    a_reload_start: assert property (reload_req && !busy_reg |=> otp_busy_out && osc_en_out)
        else $error("reload did not start otp read");
    a_load_together: assert property (load_now && !wr_commit |=>
        switcher_current_trim_out == $past(cap_reg.switcher_current_trim) &&
        linear_current_trim_out == $past(cap_reg.linear_current_trim) && burned_reg == $past(cap_reg.burned))
        else $error("otp registers not loaded together");
    a_burned_only_read: assert property (!load_now |=> $stable(burned_reg))
        else $error("burned flag changed outside otp read");
    a_osc_idle_off: assert property (!otp_busy_out |-> !osc_en_out)
        else $error("oscillator running while idle");
    a_read_bounded: assert property ($rose(otp_busy_out) |-> ##[1:200] !otp_busy_out)
        else $error("otp read did not finish");
    a_ctrl_readback: assert property (rd_value(REG_OTP_CTRL, switcher_current_trim_reg, linear_current_trim_reg, burned_reg,
        burn_reg) == (CTRL_RST | {3'h0, burned_reg, 1'b0, burn_reg, 2'h0}))
        else $error("control register readback wrong");
    a_dev_ack: assert property (scl_fall && !in_ack_reg && cnt_reg == BIT_ACK &&
        state_reg == ST_DEV && !start_cond && !stop_cond |=> sda_oe_out == $past(addr_hit))
        else $error("address acknowledge wrong");

    c_reload_done: cover property (reload_req ##[1:200] load_now);
    c_burn_on: cover property (wr_ctrl && sh_reg[2]);
    c_read_byte: cover property (state_reg == ST_RDATA && in_ack_reg && scl_rise);
    c_por_read: cover property (por_start && start_read);
endmodule
`default_nettype wire

// [test/olt_host_model.sv]
// i2c host model that programs and reads back the trim registers
`timescale 1ns/10ps
`default_nettype none
module olt_host_model
#(
    parameter int BURN_WAIT_CYC = 400
)
(
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic half();
        repeat (5) @(negedge clk_in);
    endtask
    // also serves as repeated start, scl is low on entry
    task automatic start();
        sda_out = 1'b1;
        half();
        scl_out = 1'b1;
        half();
        sda_out = 1'b0;
        half();
        scl_out = 1'b0;
        half();
    endtask
    task automatic stop();
        sda_out = 1'b0;
        half();
        scl_out = 1'b1;
        half();
        sda_out = 1'b1;
        half();
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_out = b;
        half();
        scl_out = 1'b1;
        half();
        r = sda_in;
        half();
        scl_out = 1'b0;
        half();
    endtask
    // msb first, ninth bit is the ack slot
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(last, r);
        ack = ~r;
    endtask
    task automatic wr_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                          output logic ok);
        logic [7:0] rx;
        logic k1, k2, k3;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, k1);
        xfer(a, 1'b1, rx, k2);
        xfer(d, 1'b1, rx, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask
    // address write, repeated start, one byte, nack, stop
    task automatic rd_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d);
        logic [7:0] rx;
        logic k;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, k);
        xfer(a, 1'b1, rx, k);
        start();
        xfer({dev, 1'b1}, 1'b1, rx, k);
        xfer(8'hff, 1'b1, d, k);
        stop();
    endtask
    // shortened stand-in for the burn hold time
    task automatic wait_burn();
        repeat (BURN_WAIT_CYC) @(negedge clk_in);
    endtask
endmodule
`default_nettype wire

// [test/otp_led_trim_registers_test.sv]
// self-checking testbench for the otp led trim register bank
`timescale 1ns/10ps
`default_nettype none
module otp_led_trim_registers_test;
    import olt_pkg::*;
    logic sys_clk = 1'b0;
    logic osc_clk = 1'b0;
    logic rst_n = 1'b0;
    logic power_good = 1'b1;
    olt_otp_word_t otp_word = '{burned: 1'b1, switcher_current_trim: 6'h2a, linear_current_trim: 4'h5};
    wire logic scl;
    wire logic host_sda;
    wire logic sda_wire;
    logic sda_out, sda_oe, hv, osc_en, busy;
    logic [5:0] switcher_current_trim;
    logic [3:0] linear_current_trim;
    int failures = 0;
    int samples_checked = 0;
    always #12.5 sys_clk = ~sys_clk;
    always #6 osc_clk = ~osc_clk;
    // pulled up, low only while some party pulls it
    assign sda_wire = host_sda & ~(sda_oe & ~sda_out);
    olt_host_model host (.clk_in(sys_clk), .sda_in(sda_wire), .scl_out(scl),
        .sda_out(host_sda));
    olt_trim_top dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .osc_clk_in(osc_clk),
        .scl_in(scl), .sda_in(sda_wire), .sda_out_out(sda_out), .sda_oe_out(sda_oe),
        .power_good_in(power_good), .otp_word_in(otp_word),
        .switcher_current_trim_out(switcher_current_trim), .linear_current_trim_out(linear_current_trim),
        .otp_program_supply_hv_out(hv), .osc_en_out(osc_en), .otp_busy_out(busy));
    task automatic final_report();
        if (failures == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 4000)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (busy !== lvl)
        begin
            failures++;
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        host.wr_reg(I2C_DEV_ADDR, a, d, ok);
        chk({7'h00, ok}, 8'h01);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd_reg(I2C_DEV_ADDR, a, d);
        chk(d, exp);
    endtask
    task automatic t_power_on();
        repeat (5) @(negedge sys_clk);
        chk({4'h0, linear_current_trim}, 8'h07);
        rst_n = 1'b1;
        wait_busy(1'b1);
        @(negedge sys_clk);
        chk({7'h00, osc_en}, 8'h01);
        wait_busy(1'b0);
        chk({2'b00, switcher_current_trim}, 8'h2a);
        chk({4'h0, linear_current_trim}, 8'h05);
        chk({7'h00, osc_en}, 8'h00);
        rd_chk(REG_OTP_CTRL, 8'h18);
    endtask
    task automatic t_write();
        wr(REG_SWITCHER_CURRENT_TRIM, 8'hd5);
        chk({2'b00, switcher_current_trim}, 8'h15);
        wr(REG_LINEAR_CURRENT_TRIM, 8'hfc);
        chk({4'h0, linear_current_trim}, 8'h0c);
        rd_chk(REG_SWITCHER_CURRENT_TRIM, 8'h15);
        rd_chk(REG_LINEAR_CURRENT_TRIM, 8'h0c);
        rd_chk(8'h03, 8'h00);
    endtask
    task automatic t_burn();
        wr(REG_OTP_CTRL, 8'h04);
        chk({7'h00, hv}, 8'h01);
        rd_chk(REG_OTP_CTRL, 8'h1c);
        host.wait_burn();
        wr(REG_OTP_CTRL, 8'h00);
        chk({7'h00, hv}, 8'h00);
        chk({2'b00, switcher_current_trim}, 8'h15);
    endtask
    task automatic t_reload();
        otp_word = '{burned: 1'b0, switcher_current_trim: 6'h0b, linear_current_trim: 4'h3};
        wr(REG_OTP_CTRL, 8'h01);
        wait_busy(1'b0);
        chk({2'b00, switcher_current_trim}, 8'h0b);
        chk({4'h0, linear_current_trim}, 8'h03);
        rd_chk(REG_OTP_CTRL, 8'h08);
    endtask
    task automatic t_wrong_addr();
        logic ok;
        host.wr_reg(7'h29, REG_SWITCHER_CURRENT_TRIM, 8'h3f, ok);
        chk({7'h00, ok}, 8'h00);
        chk({2'b00, switcher_current_trim}, 8'h0b);
    endtask
    task automatic t_rearm();
        power_good = 1'b0;
        otp_word = '{burned: 1'b1, switcher_current_trim: 6'h3c, linear_current_trim: 4'he};
        repeat (20) @(negedge sys_clk);
        chk({7'h00, busy}, 8'h00);
        chk({2'b00, switcher_current_trim}, 8'h0b);
        power_good = 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        chk({2'b00, switcher_current_trim}, 8'h3c);
        chk({4'h0, linear_current_trim}, 8'h0e);
        rst_n = 1'b0;
        repeat (5) @(negedge sys_clk);
        chk({2'b00, switcher_current_trim}, 8'h1f);
        chk({7'h00, hv}, 8'h00);
        rst_n = 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        chk({2'b00, switcher_current_trim}, 8'h3c);
        chk({4'h0, linear_current_trim}, 8'h0e);
        rd_chk(REG_OTP_CTRL, 8'h18);
    endtask
    initial
    begin
        t_power_on();
        t_write();
        t_burn();
        t_reload();
        t_wrong_addr();
        t_rearm();
        final_report();
    end
endmodule
`default_nettype wire
